//--- rtl/card_socket_power_irq_control.v
// Two-socket card power and interrupt control register bank
`timescale 1ns/1ps
`include "socket_ctrl_consts.vh"
module card_socket_power_irq_control
(
    // Clock and reset
    input  wire       clock,
    input  wire       rst_n,
    input  wire       clk_en,
    // Register port
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output reg        reg_hit,
    // Socket side, index 0 is socket A
    input  wire [1:0] battery_detect1_ring_pin,
    output wire [1:0] card_output_enable,
    output wire [1:0] card_reset_pin,
    output wire [1:0] card_kind_io,
    output wire [1:0] ring_indicate_enable,
    output wire [1:0] ring_indicate,
    output wire [1:0] status_change_pci_route,
    output wire [3:0] supply_voltage_request,
    output wire [3:0] program_voltage_request,
    output wire [1:0] socket_power_on_flag,
    output wire [1:0] power_switch_update,
    output wire [7:0] functional_irq_select,
    output wire [15:0] irq_line_enable,
    output wire [1:0] smi_enable
);
    // Decode a socket register address: bit 0 power, bit 1 intgen
    function [1:0] decode;
        input [7:0] addr;
        input [7:0] base;
        begin
            decode[0] = (addr == base + `OFS_A_POWER);
            decode[1] = (addr == base + `OFS_A_INTGEN);
        end
    endfunction

    // Granted supply code, reserved code means off
    function [1:0] supply_grant;
        input [1:0] vcc;
        begin
            case (vcc)
                `VCC_5V:  supply_grant = `VCC_5V;
                `VCC_3V3: supply_grant = `VCC_3V3;
                default:  supply_grant = `VCC_OFF;
            endcase
        end
    endfunction

    // Granted programming code, held off while supply is off
    function [1:0] program_grant;
        input [1:0] vcc;
        input [1:0] vpp;
        begin
            if (supply_grant(vcc) == `VCC_OFF)
            begin
                program_grant = `VPP_OFF;
            end
            else
            begin
                case (vpp)
                    `VPP_VCC: program_grant = `VPP_VCC;
                    `VPP_12V: program_grant = `VPP_12V;
                    default:  program_grant = `VPP_OFF;
                endcase
            end
        end
    endfunction

    // IRQ line decode: code n selects line n, none and SMI excluded
    function [15:0] irq_decode;
        input [3:0] code;
        begin
            irq_decode = 16'h0000;
            if ((code != `IRQ_NONE) && (code != `IRQ_SMI))
            begin
                irq_decode[code] = 1'b1;
            end
        end
    endfunction

    // Readback mux, unmapped offsets read as zero
    function [7:0] read_mux;
        input [7:0]  addr;
        input [15:0] pw_all;
        input [15:0] ig_all;
        begin
            case (addr)
                `OFS_A_POWER:  read_mux = pw_all[7:0];
                `OFS_A_INTGEN: read_mux = ig_all[7:0];
                `OFS_B_POWER:  read_mux = pw_all[15:8];
                `OFS_B_INTGEN: read_mux = ig_all[15:8];
                default:       read_mux = 8'h00;
            endcase
        end
    endfunction

    wire [15:0] power_all;
    wire [15:0] intgen_all;
    wire [1:0]  ring_q;
    wire [1:0]  hit_any;

    // Pin synchronisers, change accepted when stages 2 and 3 agree
    genvar s;
    generate
        for (s = 0; s < `SOCKET_COUNT; s = s + 1)
        begin : sync
            reg [2:0] stage_q;
            reg       agreed_q;
            always @(posedge clock)
            begin
                if (!rst_n)
                begin
                    stage_q  <= 3'h0;
                    agreed_q <= 1'b0;
                end
                else if (clk_en)
                begin
                    stage_q <= {stage_q[1:0], battery_detect1_ring_pin[s]};
                    if (stage_q[2] == stage_q[1])
                    begin
                        agreed_q <= stage_q[2];
                    end
                end
            end
            assign ring_q[s] = agreed_q;
        end
    endgenerate

    generate
        for (s = 0; s < `SOCKET_COUNT; s = s + 1)
        begin : sock
            localparam [7:0] sock_base = (s == 0) ? 8'h00 : `SOCKET_STRIDE;
            wire [1:0] hit;
            wire [7:0] pw;
            wire [7:0] ig;
            wire [1:0] vcc_grant;
            wire [1:0] vpp_grant;
            wire [3:0] sel;

            assign hit       = decode(reg_addr, sock_base);
            assign pw        = power_all[8*s +: 8];
            assign ig        = intgen_all[8*s +: 8];
            assign vcc_grant = supply_grant(pw[4:3]);
            assign vpp_grant = program_grant(pw[4:3], pw[1:0]);
            assign sel       = ig[3:0];
            assign hit_any[s] = |hit;

            socket_regs u_regs
            (
                .clock        (clock),
                .rst_n        (rst_n),
                .clk_en       (clk_en),
                .wr_power     (reg_wr & hit[0]),
                .wr_intgen    (reg_wr & hit[1]),
                .wr_data      (reg_wdata),
                .power_q      (power_all[8*s +: 8]),
                .intgen_q     (intgen_all[8*s +: 8]),
                .power_change (power_switch_update[s])
            );
            assign card_output_enable[s]      = pw[`BIT_OUT_EN];
            assign supply_voltage_request[2*s +: 2]  = vcc_grant;
            assign program_voltage_request[2*s +: 2] = vpp_grant;
            assign socket_power_on_flag[s]    = (vcc_grant != `VCC_OFF)
                                              && (vpp_grant != `VPP_OFF);
            assign ring_indicate_enable[s]    = ig[`BIT_RING_EN];
            assign ring_indicate[s]           = ig[`BIT_RING_EN] & ring_q[s];
            assign card_reset_pin[s]          = ~ig[`BIT_CARD_RUN];
            assign card_kind_io[s]            = ig[`BIT_CARD_IO];
            assign status_change_pci_route[s] = ig[`BIT_CSC_PCI] | (sel == `IRQ_NONE);
            assign functional_irq_select[4*s +: 4] = sel;
            assign smi_enable[s]              = (sel == `IRQ_SMI);
        end
    endgenerate

    // IRQ lines requested by either socket
    reg [15:0] irq_vec_a;
    reg [15:0] irq_vec_b;
    always @*
    begin
        irq_vec_a = irq_decode(intgen_all[3:0]);
        irq_vec_b = irq_decode(intgen_all[11:8]);
    end

    assign irq_line_enable = irq_vec_a | irq_vec_b;

    // Register readback
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
            reg_hit   <= 1'b0;
        end
        else if (clk_en)
        begin
            reg_hit <= (reg_rd | reg_wr) & (|hit_any);
            if (reg_rd)
            begin
                reg_rdata <= read_mux(reg_addr, power_all, intgen_all);
            end
        end
    end
endmodule

//--- pkg/socket_ctrl_consts.vh
// Register offsets, field positions and codes of the socket control bank
`ifndef SOCKET_CTRL_CONSTS_VH
`define SOCKET_CTRL_CONSTS_VH
`define OFS_A_POWER        8'h02
`define OFS_A_INTGEN       8'h03
`define OFS_B_POWER        8'h42
`define OFS_B_INTGEN       8'h43
`define SOCKET_STRIDE      8'h40
`define SOCKET_COUNT       2
`define POWER_RESET        8'h00
`define INTGEN_RESET       8'h00
`define POWER_WMASK        8'h9b
`define BIT_OUT_EN         7
`define BIT_RING_EN        7
`define BIT_CARD_RUN       6
`define BIT_CARD_IO        5
`define BIT_CSC_PCI        4
`define VCC_OFF            2'h0
`define VCC_RSVD           2'h1
`define VCC_5V             2'h2
`define VCC_3V3            2'h3
`define VPP_OFF            2'h0
`define VPP_VCC            2'h1
`define VPP_12V            2'h2
`define VPP_RSVD           2'h3
`define IRQ_NONE           4'h0
`define IRQ_SMI            4'h2
`endif

//--- rtl/socket_regs.v
// One socket's power and interrupt/general control registers
`timescale 1ns/1ps
`include "socket_ctrl_consts.vh"
module socket_regs
(
    // Clock and reset
    input  wire       clock,
    input  wire       rst_n,
    input  wire       clk_en,
    // Register writes
    input  wire       wr_power,
    input  wire       wr_intgen,
    input  wire [7:0] wr_data,
    // Stored values
    output reg  [7:0] power_q,
    output reg  [7:0] intgen_q,
    output reg        power_change
);
    reg [7:0] power_d;
    always @*
    begin
        power_d = wr_data & `POWER_WMASK;
    end
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            power_q      <= `POWER_RESET;
            intgen_q     <= `INTGEN_RESET;
            power_change <= 1'b0;
        end
        else if (clk_en)
        begin
            power_change <= 1'b0;
            if (wr_power)
            begin
                power_q      <= power_d;
                power_change <= (power_d[4:0] != power_q[4:0]);
            end
            if (wr_intgen)
                intgen_q <= wr_data;
        end
    end
endmodule

//--- testbench/card_socket_power_irq_control_monitor.sv
// Assertion checker for the socket control bank
`timescale 1ns/1ps
module socket_ctrl_monitor
(
    // Clock and register port
    input wire clock,
    input wire rst_n,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_hit,
    // Socket side
    input wire [1:0] card_output_enable,
    input wire [1:0] card_reset_pin,
    input wire [1:0] status_change_pci_route,
    input wire [3:0] supply_voltage_request,
    input wire [3:0] program_voltage_request,
    input wire [1:0] socket_power_on_flag,
    input wire [7:0] functional_irq_select
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire wr_en = reg_wr && clk_en;
    a_oe_follows_write: assert property (wr_en && reg_addr == 8'h02 |=>
        card_output_enable[0] == $past(reg_wdata[7])) else $error("oe");
    a_rsvd_read_zero: assert property (reg_rd && clk_en && reg_addr == 8'h42 |=>
        reg_hit && (reg_rdata & 8'h64) == 8'h00) else $error("rsvd");
    a_vcc_code_valid: assert property (supply_voltage_request[0] |->
        supply_voltage_request[1]) else $error("vcc");
    a_vpp_needs_vcc: assert property (program_voltage_request[1:0] != 2'h0 |->
        supply_voltage_request[1]) else $error("vpp");
    a_reset_pin_write: assert property (wr_en && reg_addr == 8'h03 |=>
        card_reset_pin[0] == !$past(reg_wdata[6])) else $error("reset");
    a_zero_code_route: assert property (functional_irq_select[3:0] == 4'h0 |->
        status_change_pci_route[0]) else $error("route");
    a_socket_b_apart: assert property (wr_en && reg_addr == 8'h43 |=>
        card_reset_pin == {!$past(reg_wdata[6]), $past(card_reset_pin[0])}) else $error("b");
    a_power_flag_on: assert property (socket_power_on_flag[0] ==
        (supply_voltage_request[1] && program_voltage_request[1:0] != 2'h0)) else $error("pf");
    c_write_b: cover property (wr_en && reg_addr == 8'h42);
    c_power_on: cover property (socket_power_on_flag[1]);
    c_unmapped: cover property (reg_rd && reg_addr == 8'h41);
endmodule
bind card_socket_power_irq_control socket_ctrl_monitor i_mon (.*);

//--- testbench/card_pair_model.sv
// Behavioural pair of cards driving the ring-indicate pins
`timescale 1ns/1ps
module card_pair_model
(
    // Clock and card controls
    input wire clock,
    input wire [1:0] ring,
    input wire [1:0] card_reset_pin,
    // Card pins
    output reg [1:0] battery_detect1_ring_pin = 2'h0
);
    always @(posedge clock)
        battery_detect1_ring_pin <= #1 ring & ~card_reset_pin;
endmodule

//--- testbench/test_card_socket_power_irq_control.sv
// Self-checking bench for the socket control bank
`timescale 1ns/1ps
module test_card_socket_power_irq_control;
    reg clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, clk_en = 1;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, m [0:3];
    reg [1:0] ring = 2'h0;
    reg [31:0] seed = 32'd30830;
    integer err_count = 0, total_checks = 0, cyc = 0, i, s;
    wire [7:0] reg_rdata, functional_irq_select;
    wire [3:0] supply_voltage_request, program_voltage_request;
    wire [15:0] irq_line_enable;
    wire [1:0] battery_detect1_ring_pin, card_output_enable, card_reset_pin, card_kind_io,
        ring_indicate_enable, ring_indicate, status_change_pci_route, socket_power_on_flag,
        power_switch_update, smi_enable;
    wire reg_hit;
    always #4 clock = ~clock;
    card_socket_power_irq_control i_dut (.*);
    card_pair_model i_card (.clock, .ring, .card_reset_pin, .battery_detect1_ring_pin);
    task cmp(input string what, input [15:0] exp, input [15:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                err_count = err_count + 1;
                $display("Error %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task cmp_pins;
        reg [7:0] p, g;
        reg on;
        for (s = 0; s < 2; s = s + 1)
        begin
            p = m[2 * s];
            g = m[2 * s + 1];
            on = p[4] && (p[1:0] == 2'h1 || p[1:0] == 2'h2);
            cmp("pins", {p[7], !g[6], g[5], g[7], g[4] || g[3:0] == 4'h0,
                p[4] ? p[4:3] : 2'h0, on ? p[1:0] : 2'h0, on, g[3:0], g[3:0] == 4'h2},
                {card_output_enable[s], card_reset_pin[s], card_kind_io[s],
                ring_indicate_enable[s], status_change_pci_route[s],
                supply_voltage_request[2 * s +: 2], program_voltage_request[2 * s +: 2],
                socket_power_on_flag[s], functional_irq_select[4 * s +: 4], smi_enable[s]});
        end
    endtask
    task access(input w, input [7:0] a, input [7:0] d);
        reg hit;
        reg [7:0] old;
        reg [15:0] irq_exp;
        begin
            hit = a[7] == 1'b0 && a[5:1] == 5'h01;
            old = m[{a[6], a[0]}];
            @(posedge clock);
            #1 reg_addr = a;
            reg_wdata = d;
            reg_wr = w;
            reg_rd = !w;
            @(posedge clock);
            #1 reg_wr = 0;
            reg_rd = 0;
            if (w && hit)
                m[{a[6], a[0]}] = a[0] ? d : d & 8'h9b;
            cmp("hit", hit, reg_hit);
            if (!w)
                cmp("read data", hit ? old : 8'h00, reg_rdata);
            cmp("switch update", {1'b0, w && hit && !a[0] &&
                old[4:0] != m[{a[6], a[0]}][4:0]} << a[6], power_switch_update);
            cmp_pins;
            irq_exp = 16'h0000;
            for (s = 0; s < 2; s = s + 1)
                if (m[2 * s + 1][3:0] != 4'h0 && m[2 * s + 1][3:0] != 4'h2)
                    irq_exp[m[2 * s + 1][3:0]] = 1'b1;
            cmp("irq lines", irq_exp, irq_line_enable);
        end
    endtask
    task tally_and_finish;
        begin
            $display("Checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    always @(posedge clock)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            err_count = err_count + 1;
            tally_and_finish;
        end
    end
    initial
    begin
        for (i = 0; i < 4; i = i + 1)
            m[i] = 8'h00;
        repeat (6) @(posedge clock);
        #1 rst_n = 1;
        for (i = 0; i < 4; i = i + 1)
            access(0, {1'b0, i[1], 5'h01, i[0]}, 8'h00);
        $display("Reset values done");
        for (i = 0; i < 300; i = i + 1)
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            access(seed[8], {1'b0, seed[9], 4'h0, seed[12] | seed[13], seed[10]}, seed[23:16]);
        end
        $display("Random access done");
        access(1, 8'h03, 8'hc0);
        access(1, 8'h43, 8'hc0);
        ring = 2'h3;
        repeat (8) @(posedge clock);
        #1 cmp("ring", 2'h3, ring_indicate);
        access(1, 8'h43, 8'h40);
        cmp("ring", 2'h1, ring_indicate);
        $display("Ring indicate done");
        @(posedge clock);
        #1 clk_en = 0;
        reg_addr = 8'h02;
        reg_wdata = ~m[0];
        reg_wr = 1;
        @(posedge clock);
        #1 reg_wr = 0;
        clk_en = 1;
        cmp("frozen hit", 1'b0, reg_hit);
        cmp_pins;
        $display("Clock enable done");
        tally_and_finish;
    end
endmodule
